//--- testbench/fsr_host.sv
`timescale 1ns/1ps
// ====
// Host model, mode 0, 80 ns link clock
module fsr_host (
  // Link out
  output logic sck,
  output logic csN,
  output logic si,
  // Link in
  input wire logic so,
  input wire logic soOe
);
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
  end
  // One frame, MSB first; last byte on so returned
  task automatic frame(input logic [47:0] d, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    #37 csN = 1'b0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      si = d[i];
      #40 sck = 1'b1;
      rd = {rd[6:0], so & soOe};
      #40 sck = 1'b0;
    end
    #40 csN = 1'b1;
    // Released line flips so a stale bit cannot pass
    si = ~si;
    #120;
  endtask : frame
endmodule : fsr_host

//--- testbench/fsr_status_one_assertions.sv
`timescale 1ns/1ps
module fsr_status_one_assertions import fsr_pkg::*; (
  // System
  input wire logic clk,
  input wire logic rst,
  // Engine
  input wire logic opStart,
  input wire fsr_kind_t opKind,
  input wire logic suspendReq,
  input wire logic resumeReq,
  input wire logic opAbort,
  input wire logic opDone,
  input wire logic opFail,
  input wire logic opProtHit,
  // Registers
  input wire logic [7:0] statusOneVolatile,
  input wire logic [7:0] statusOneNonvolatile,
  input wire logic [7:0] configOneNonvolatile
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] v;
  logic [7:0] n;
  logic susp;
  assign v = statusOneVolatile;
  assign n = statusOneNonvolatile;
  // Suspension is not visible in status, so track it from the pulses
  always_ff @(posedge clk)
  begin
    if (rst || resumeReq || opAbort)
      susp <= 1'b0;
    else if (suspendReq)
      susp <= 1'b1;
  end
  // ====
  // Completion of a running, clean operation
  sequence s_done;
    opDone && v[0] && !susp && !v[6] && !v[5];
  endsequence
  sequence s_ok;
    s_done ##0 !opFail && !opProtHit;
  endsequence
  a_lock_copy: assert property ($changed(n[7]) |=> v[7] == $past(n[7]))
    else $error("lock copy lost");
  a_err_busy: assert property ((v[6] || v[5]) |-> v[0])
    else $error("error without busy");
  a_start_latch: assert property (opStart |-> v[1] && v[0])
    else $error("start without latch");
  a_whole_clear: assert property (opStart && opKind == KIND_WHOLE_ERASE |-> v[4:2] == 3'h0)
    else $error("whole erase protected");
  a_done_ok: assert property (s_ok |=> v[1:0] == 2'b00)
    else $error("latch kept after success");
  a_prog_fail: assert property (s_done ##0 opFail && opKind == KIND_PROGRAM |=> v[6] && v[0])
    else $error("program error missing");
  a_erase_fail: assert property (s_done ##0 opFail && opKind == KIND_SECTOR_ERASE |=> v[5] && v[0])
    else $error("erase error missing");
  a_whole_hit: assert property (s_done ##0 opProtHit && opKind == KIND_WHOLE_ERASE |=> !v[5])
    else $error("whole erase set error");
  a_bp_mirror: assert property (!configOneNonvolatile[3] |-> v[4:2] == n[4:2])
    else $error("protect copy differs");
  a_nv_fixed: assert property (configOneNonvolatile[3] && $past(configOneNonvolatile[3]) |-> $stable(n[4:2]))
    else $error("nv protect changed");
endmodule : fsr_status_one_assertions
bind fsr_status_one fsr_status_one_assertions u_fsr_status_one_assertions (.clk(clk), .rst(rst),
  .opStart(opStart), .opKind(opKind), .suspendReq(suspendReq), .resumeReq(resumeReq), .opAbort(opAbort),
  .opDone(opDone), .opFail(opFail), .opProtHit(opProtHit), .statusOneVolatile(statusOneVolatile),
  .statusOneNonvolatile(statusOneNonvolatile), .configOneNonvolatile(configOneNonvolatile));

//--- testbench/tb_fsr_status_one.sv
`timescale 1ns/1ps
module tb_fsr_status_one import fsr_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wpN = 1'b1, opDone = 1'b0, opFail = 1'b0, opProtHit = 1'b0;
  logic sck, csN, si, so, soOe, opStart, suspendReq, resumeReq, opAbort;
  fsr_kind_t opKind;
  logic [23:0] opAddr;
  logic [7:0] sv, snv, cnv, rd;
  int badCount = 0, nChecks = 0, starts = 0, susps = 0, resumes = 0, aborts = 0;
  always #5 clk = ~clk;
  // Pulse counters
  always @(posedge clk)
  begin
    starts <= starts + opStart;
    susps <= susps + suspendReq;
    resumes <= resumes + resumeReq;
    aborts <= aborts + opAbort;
  end
  fsr_status_one u_fsr_status_one (.clk(clk), .rst(rst), .sck(sck), .csN(csN), .si(si), .wpN(wpN),
    .so(so), .soOe(soOe), .opStart(opStart), .opKind(opKind), .opAddr(opAddr), .suspendReq(suspendReq),
    .resumeReq(resumeReq), .opAbort(opAbort), .opDone(opDone), .opFail(opFail), .opProtHit(opProtHit),
    .statusOneVolatile(sv), .statusOneNonvolatile(snv), .configOneNonvolatile(cnv));
  fsr_host u_fsr_host (.sck(sck), .csN(csN), .si(si), .so(so), .soOe(soOe));
  // ====
  // Shared steps
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(input logic [47:0] d, input int nb);
    u_fsr_host.frame(d, nb, rd);
  endtask : cmd
  task automatic done(input logic f, input logic p);
    @(posedge clk);
    opDone <= 1'b1;
    opFail <= f;
    opProtHit <= p;
    @(posedge clk);
    opDone <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : done
  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ====
  // Scenarios
  task automatic t_reset();
    chk("status", 8'h00, sv);
    chk("nv status", 8'h00, snv);
    cmd(16'h0500, 16);
    chk("status read", 8'h00, rd);
    cmd(8'h06, 8);
    chk("latch set", 8'h02, sv);
    cmd(16'h0500, 16);
    chk("status read", 8'h02, rd);
    cmd(8'h04, 8);
    chk("latch clear", 8'h00, sv);
    $display("reset and latch test done");
  endtask : t_reset
  task automatic t_write();
    cmd(16'h01EB, 16);
    chk("write refused", 8'h00, snv);
    cmd(8'h06, 8);
    cmd(16'h01EB, 16);
    chk("nv write", 8'h88, snv);
    chk("vol copy", 8'h88, sv);
    @(posedge clk) wpN <= 1'b0;
    cmd(8'h06, 8);
    cmd(16'h0100, 16);
    chk("locked", 8'h8A, sv);
    @(posedge clk) wpN <= 1'b1;
    cmd(16'h0100, 16);
    chk("unlocked", 8'h00, sv);
    $display("write test done");
  endtask : t_write
  task automatic t_program();
    int s0 = starts;
    cmd(8'h06, 8);
    cmd(32'h0212_3456, 32);
    chk("start", s0 + 1, starts);
    chk("addr", 24'h12_3456, opAddr);
    chk("kind", KIND_PROGRAM, opKind);
    cmd(16'h011C, 16);
    chk("busy refuses", 8'h00, snv);
    cmd(16'h0500, 16);
    chk("busy read", 8'h03, rd);
    done(1'b1, 1'b0);
    chk("prog fail", 8'h43, sv);
    cmd(8'h30, 8);
    chk("cleared", 8'h02, sv);
    cmd(8'h04, 8);
    cmd(8'h06, 8);
    cmd(32'h0200_0000, 32);
    done(1'b0, 1'b0);
    chk("prog ok", 8'h00, sv);
    $display("program test done");
  endtask : t_program
  task automatic t_erase();
    int s0 = starts;
    int p0 = susps;
    int r0 = resumes;
    int a0 = aborts;
    cmd(8'h06, 8);
    cmd(40'h71_0000_0004, 40);
    cmd(40'h65_0000_0000, 40);
    chk("read any", 8'h04, rd);
    cmd(8'h06, 8);
    cmd(32'hD8FC_0000, 32);
    chk("prot erase", 8'h27, sv);
    cmd(8'h82, 8);
    chk("cleared", 8'h06, sv);
    cmd(32'h02FC_0000, 32);
    chk("prot prog", 8'h47, sv);
    cmd(8'h30, 8);
    cmd(8'h60, 8);
    chk("bulk refused", s0, starts);
    cmd(16'h0100, 16);
    cmd(8'h06, 8);
    cmd(8'hC7, 8);
    chk("bulk start", KIND_WHOLE_ERASE, opKind);
    done(1'b1, 1'b1);
    chk("bulk prot hit", 8'h02, sv);
    cmd(8'hC7, 8);
    cmd(8'h85, 8);
    chk("wrong suspend", p0, susps);
    cmd(8'h75, 8);
    chk("erase suspend", p0 + 1, susps);
    cmd(8'h7A, 8);
    chk("resume", 8'h03, sv);
    chk("resume pulse", r0 + 1, resumes);
    cmd(8'hF0, 8);
    chk("soft reset", 8'h00, sv);
    chk("abort pulse", a0 + 1, aborts);
    $display("erase test done");
  endtask : t_erase
  task automatic t_volatile();
    cmd(8'h06, 8);
    cmd(24'h01_0008, 24);
    chk("config", 8'h08, cnv);
    chk("nv protect", 8'h1C, snv);
    cmd(8'h06, 8);
    cmd(16'h0104, 16);
    chk("vol protect", 8'h04, sv);
    chk("nv kept", 8'h1C, snv);
    cmd(8'h06, 8);
    cmd(32'h2000_0000, 32);
    chk("kind", KIND_SECTOR_ERASE, opKind);
    done(1'b1, 1'b0);
    chk("erase fail", 8'h27, sv);
    cmd(8'h30, 8);
    chk("cleared", 8'h06, sv);
    $display("volatile protect test done");
  endtask : t_volatile
  // ====
  // Main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset();
    t_write();
    t_program();
    t_erase();
    t_volatile();
    conclude();
  end
  initial
  begin
    #900000;
    badCount++;
    conclude();
  end
endmodule : tb_fsr_status_one

//--- verilog/fsr_pkg.sv
// Functional notes
// - Non-volatile protect mode: write both copies
// - Volatile protect mode: write volatile bits only
// - Refuse program/erase inside protected region
// - Whole-array erase only with all protect bits clear
// - Volatile write-lock copy follows non-volatile bit
// - Program failure or protected program sets flag
// - Erase failure or protected sector erase sets flag
// - Whole-array erase protected hit sets no flag
// - Clear-status or soft reset clears both failure flags
// - Decode register, enable and disable opcodes
// - Write-enable command sets latch
// - Write-disable command clears latch
// - Latch clear ignores writes, program, erase
// - Successful operation clears the latch
// - Any reset forces latch to zero
// - Busy accepts only the listed commands
// - Suspend only while matching operation runs
// - Failure keeps busy until clear-status
// - Read-status-one returns the volatile copy
// - Fixed defaults seed latch and busy at reset
// - Write-lock with protect pin low blocks writes
package fsr_pkg;

  // ==========================================================
  // Command opcodes
  localparam logic [7:0] OPC_WRITE_REGS = 8'h01;
  localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] OPC_SMALL_ERASE = 8'h20;
  localparam logic [7:0] OPC_CLEAR_STATUS_A = 8'h30;
  localparam logic [7:0] OPC_WHOLE_ERASE_A = 8'h60;
  localparam logic [7:0] OPC_READ_ANY = 8'h65;
  localparam logic [7:0] OPC_WRITE_ANY = 8'h71;
  localparam logic [7:0] OPC_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7A;
  localparam logic [7:0] OPC_CLEAR_STATUS_B = 8'h82;
  localparam logic [7:0] OPC_PROGRAM_SUSPEND = 8'h85;
  localparam logic [7:0] OPC_SUSPEND_ANY = 8'hB0;
  localparam logic [7:0] OPC_WHOLE_ERASE_B = 8'hC7;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OPC_SOFT_RESET = 8'hF0;

  // ==========================================================
  // Register addresses for read-any / write-any
  localparam logic [23:0] ADDR_STATUS_ONE_NV = 24'h00_0000;
  localparam logic [23:0] ADDR_CONFIG_ONE_NV = 24'h00_0002;
  localparam logic [23:0] ADDR_STATUS_ONE_VOL = 24'h80_0000;
  localparam int ADDR_BYTES = 3;

  // ==========================================================
  // Field positions
  localparam int BIT_WRITE_LOCK = 7;
  localparam int BIT_PROG_ERR = 6;
  localparam int BIT_ERASE_ERR = 5;
  localparam int BIT_PROTECT_HI = 4;
  localparam int BIT_PROTECT_LO = 2;
  localparam int BIT_WRITE_ENABLE = 1;
  localparam int BIT_BUSY = 0;
  localparam int CFG_BIT_FROM_BOTTOM = 5;
  localparam int CFG_BIT_PROTECT_VOL = 3;
  localparam int SECTOR_IDX_W = 6;

  // ==========================================================
  // Shipped and reset defaults
  localparam logic WRITE_LOCK_DEFAULT = 1'b0;
  localparam logic [2:0] PROTECT_DEFAULT = 3'h0;
  localparam logic PROG_ERR_DEFAULT = 1'b0;
  localparam logic ERASE_ERR_DEFAULT = 1'b0;
  localparam logic WRITE_LATCH_DEFAULT = 1'b0;
  localparam logic BUSY_FLAG_DEFAULT = 1'b0;
  localparam logic FROM_BOTTOM_DEFAULT = 1'b0;
  localparam logic PROTECT_VOL_DEFAULT = 1'b0;
  localparam logic [2:0] PROTECT_ALL = 3'h7;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    KIND_PROGRAM = 2'b00,
    KIND_SECTOR_ERASE = 2'b01,
    KIND_WHOLE_ERASE = 2'b10
  } fsr_kind_t;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_IGNORE = 2'b11
  } fsr_phase_t;

endpackage : fsr_pkg

//--- verilog/fsr_protect.sv
`timescale 1ns/1ps
// Maps the active protect bits onto a protected sector window
module fsr_protect import fsr_pkg::*; #(
  parameter int IDX_W = SECTOR_IDX_W
) (
  // Protect setting
  input wire logic [2:0] protect,
  input wire logic fromBottom,
  // Target sector
  input wire logic [IDX_W-1:0] sectorIdx,
  output logic hit
);

  localparam logic [IDX_W:0] FULL = (IDX_W+1)'(1) << IDX_W;
  logic [IDX_W:0] span;
  logic [IDX_W:0] idx;

  // Window doubles per step; all-ones covers the whole array
  always_comb
  begin
    idx = {1'b0, sectorIdx};
    if (protect == 3'h0)
      span = '0;
    else if (protect == PROTECT_ALL)
      span = FULL;
    else
      span = (IDX_W+1)'(1) << (protect - 3'h1);
    if (fromBottom)
      hit = (idx < span);
    else
      hit = (idx >= FULL - span);
  end

endmodule : fsr_protect

//--- verilog/fsr_status_one.sv
`timescale 1ns/1ps
// Status register one: serial command front end, register copies,
// write-enable latch, busy and failure flags
module fsr_status_one import fsr_pkg::*; (
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial link pins; inputs asynchronous to clk, so and soOe registered on clk
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic wpN,
  output logic so,
  output logic soOe,
  // Array engine
  output logic opStart,
  output fsr_kind_t opKind,
  output logic [23:0] opAddr,
  output logic suspendReq,
  output logic resumeReq,
  output logic opAbort,
  input wire logic opDone,
  input wire logic opFail,
  input wire logic opProtHit,
  // Register views
  output logic [7:0] statusOneVolatile,
  output logic [7:0] statusOneNonvolatile,
  output logic [7:0] configOneNonvolatile
);

  // ==========================================================
  // Pin sampling
  logic [3:0] pinSync;
  logic sckQ;
  logic csNQ;
  logic siQ;
  logic wpNQ;
  logic sckPrev;
  logic csNPrev;
  logic sckRise;
  logic sckFall;
  logic frameEnd;

  fsr_sync #(
    .WIDTH(4),
    .RESET_VAL(4'b0101)
  ) uPinSync (
    .clk(clk),
    .rst(rst),
    .d({sck, csN, si, wpN}),
    .q(pinSync)
  );

  assign sckQ = pinSync[3];
  assign csNQ = pinSync[2];
  assign siQ = pinSync[1];
  assign wpNQ = pinSync[0];

  // Edge history of the synchronised link clock and select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sckPrev <= 1'b0;
      csNPrev <= 1'b1;
    end
    else
    begin
      sckPrev <= sckQ;
      csNPrev <= csNQ;
    end
  end

  assign sckRise = sckQ & ~sckPrev & ~csNQ;
  assign sckFall = ~sckQ & sckPrev & ~csNQ;
  assign frameEnd = csNQ & ~csNPrev;

  // ==========================================================
  // Register state
  logic lockNv;
  logic [2:0] nvProtect;
  logic fromBottom;
  logic protectVol;
  logic lockCopy;
  logic progErr;
  logic eraseErr;
  logic [2:0] volProtect;
  logic writeLatch;
  logic busy;
  logic running;
  logic suspended;
  fsr_kind_t runKind;
  logic [2:0] activeProtect;

  assign activeProtect = protectVol ? volProtect : nvProtect;
  assign statusOneVolatile = {lockCopy, progErr, eraseErr, volProtect, writeLatch, busy};
  assign statusOneNonvolatile = {lockNv, PROG_ERR_DEFAULT, ERASE_ERR_DEFAULT, nvProtect,
                                 WRITE_LATCH_DEFAULT, BUSY_FLAG_DEFAULT};
  assign configOneNonvolatile = {2'b00, fromBottom, 1'b0, protectVol, 3'b000};

  // ==========================================================
  // Frame decoding
  fsr_phase_t phase;
  logic [2:0] bitCnt;
  logic [6:0] shiftIn;
  logic [7:0] opcode;
  logic [1:0] addrCnt;
  logic [23:0] addr;
  logic [1:0] dataCnt;
  logic [7:0] data0;
  logic [7:0] data1;
  logic byteDone;
  logic [7:0] byteIn;
  logic cmdAccept;
  logic cmdNeedsAddr;

  assign byteDone = sckRise && (bitCnt == 3'h7);
  assign byteIn = {shiftIn, siQ};

  // Known opcode, filtered by busy and by the running operation
  always_comb
  begin
    cmdNeedsAddr = 1'b0;
    unique case (byteIn)
      OPC_READ_STATUS_ONE, OPC_READ_STATUS_TWO, OPC_CLEAR_STATUS_A, OPC_CLEAR_STATUS_B,
      OPC_SOFT_RESET:
        cmdAccept = 1'b1;
      OPC_READ_ANY:
      begin
        cmdAccept = 1'b1;
        cmdNeedsAddr = 1'b1;
      end
      OPC_ERASE_SUSPEND:
        cmdAccept = busy && running && (runKind != KIND_PROGRAM);
      OPC_PROGRAM_SUSPEND:
        cmdAccept = busy && running && (runKind == KIND_PROGRAM);
      OPC_SUSPEND_ANY:
        cmdAccept = busy && running;
      OPC_RESUME:
        cmdAccept = !busy && suspended;
      OPC_WRITE_ANY, OPC_PAGE_PROGRAM, OPC_SECTOR_ERASE, OPC_SMALL_ERASE:
      begin
        cmdAccept = !busy;
        cmdNeedsAddr = 1'b1;
      end
      OPC_WRITE_REGS, OPC_WRITE_ENABLE, OPC_WRITE_DISABLE, OPC_WHOLE_ERASE_A, OPC_WHOLE_ERASE_B:
        cmdAccept = !busy;
      default:
        cmdAccept = 1'b0;
    endcase
  end

  // Bit and byte bookkeeping; refused frames park in the ignore phase
  always_ff @(posedge clk)
  begin
    if (rst || csNQ)
    begin
      phase <= PH_CMD;
      bitCnt <= 3'h0;
      addrCnt <= 2'h0;
      dataCnt <= 2'h0;
    end
    else if (sckRise)
    begin
      bitCnt <= bitCnt + 3'h1;
      if (byteDone)
      begin
        unique case (phase)
          PH_CMD:
            if (!cmdAccept)
              phase <= PH_IGNORE;
            else if (cmdNeedsAddr)
              phase <= PH_ADDR;
            else
              phase <= PH_DATA;
          PH_ADDR:
          begin
            addrCnt <= addrCnt + 2'h1;
            if (addrCnt == 2'(ADDR_BYTES - 1))
              phase <= PH_DATA;
          end
          PH_DATA:
            if (dataCnt != 2'h2)
              dataCnt <= dataCnt + 2'h1;
          PH_IGNORE:
            phase <= PH_IGNORE;
        endcase
      end
    end
  end

  // Data path of the frame
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shiftIn <= 7'h00;
      opcode <= 8'h00;
      addr <= 24'h00_0000;
      data0 <= 8'h00;
      data1 <= 8'h00;
    end
    else if (sckRise)
    begin
      shiftIn <= byteIn[6:0];
      if (byteDone && phase == PH_CMD)
        opcode <= byteIn;
      if (byteDone && phase == PH_ADDR)
        addr <= {addr[15:0], byteIn};
      if (byteDone && phase == PH_DATA && dataCnt == 2'h0)
        data0 <= byteIn;
      if (byteDone && phase == PH_DATA && dataCnt == 2'h1)
        data1 <= byteIn;
    end
  end

  // ==========================================================
  // Command execution at the rising select, whole bytes only
  logic execOp;
  logic writeAllowed;
  logic doEnable;
  logic doDisable;
  logic doClear;
  logic doSoftReset;
  logic doWrr;
  logic doWrar;
  logic doProgram;
  logic doSector;
  logic doWhole;
  logic doSuspend;
  logic doResume;
  logic protHit;
  logic wrStatusNv;
  logic wrStatusVol;
  logic wrConfig;
  logic [7:0] configData;
  logic engineEnd;
  logic engineOk;
  logic setProgErr;
  logic setEraseErr;
  logic startOp;

  fsr_protect uProtect (
    .protect(activeProtect),
    .fromBottom(fromBottom),
    .sectorIdx(addr[23 -: SECTOR_IDX_W]),
    .hit(protHit)
  );

  assign execOp = frameEnd && (phase == PH_DATA) && (bitCnt == 3'h0);
  assign writeAllowed = writeLatch && !(lockNv && !wpNQ);
  assign doEnable = execOp && (opcode == OPC_WRITE_ENABLE);
  assign doDisable = execOp && (opcode == OPC_WRITE_DISABLE);
  assign doClear = execOp && (opcode == OPC_CLEAR_STATUS_A || opcode == OPC_CLEAR_STATUS_B);
  assign doSoftReset = execOp && (opcode == OPC_SOFT_RESET);
  assign doWrr = execOp && (opcode == OPC_WRITE_REGS) && (dataCnt != 2'h0) && writeAllowed;
  assign doWrar = execOp && (opcode == OPC_WRITE_ANY) && (dataCnt != 2'h0) && writeAllowed;
  assign doProgram = execOp && (opcode == OPC_PAGE_PROGRAM) && writeLatch && !running;
  assign doSector = execOp && (opcode == OPC_SECTOR_ERASE || opcode == OPC_SMALL_ERASE)
                    && writeLatch && !running;
  assign doWhole = execOp && (opcode == OPC_WHOLE_ERASE_A || opcode == OPC_WHOLE_ERASE_B)
                   && writeLatch && !running && (activeProtect == 3'h0);
  assign doSuspend = execOp && (opcode == OPC_ERASE_SUSPEND || opcode == OPC_PROGRAM_SUSPEND
                                || opcode == OPC_SUSPEND_ANY);
  assign doResume = execOp && (opcode == OPC_RESUME);

  // Register write targets; a second write-registers byte reaches config one
  assign wrStatusNv = doWrr || (doWrar && addr == ADDR_STATUS_ONE_NV);
  assign wrStatusVol = doWrr || (doWrar && addr == ADDR_STATUS_ONE_VOL);
  assign wrConfig = (doWrr && dataCnt == 2'h2) || (doWrar && addr == ADDR_CONFIG_ONE_NV);
  assign configData = doWrr ? data1 : data0;

  // Engine results and array requests
  assign engineEnd = opDone && running && !suspended;
  assign engineOk = engineEnd && !opFail;
  assign setProgErr = (doProgram && protHit)
                      || (engineEnd && opFail && runKind == KIND_PROGRAM);
  assign setEraseErr = (doSector && protHit)
                       || (engineEnd && opFail && runKind == KIND_SECTOR_ERASE)
                       || (engineEnd && opFail && !opProtHit && runKind == KIND_WHOLE_ERASE);
  assign startOp = (doProgram && !protHit) || (doSector && !protHit) || doWhole;

  // ==========================================================
  // Non-volatile copies; only a full power-up reset reloads them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lockNv <= WRITE_LOCK_DEFAULT;
      nvProtect <= PROTECT_DEFAULT;
      fromBottom <= FROM_BOTTOM_DEFAULT;
      protectVol <= PROTECT_VOL_DEFAULT;
    end
    else
    begin
      if (wrStatusNv)
      begin
        lockNv <= data0[BIT_WRITE_LOCK];
        if (!protectVol)
          nvProtect <= data0[BIT_PROTECT_HI:BIT_PROTECT_LO];
      end
      // One-time bits: writing zero never takes a set bit back
      if (wrConfig)
      begin
        fromBottom <= fromBottom | configData[CFG_BIT_FROM_BOTTOM];
        protectVol <= protectVol | configData[CFG_BIT_PROTECT_VOL];
        if (!protectVol && configData[CFG_BIT_PROTECT_VOL])
          nvProtect <= PROTECT_ALL;
      end
    end
  end

  // Volatile copies of protect and write-lock bits
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      volProtect <= PROTECT_DEFAULT;
      lockCopy <= WRITE_LOCK_DEFAULT;
    end
    else if (doSoftReset)
    begin
      volProtect <= nvProtect;
      lockCopy <= lockNv;
    end
    else
    begin
      lockCopy <= lockNv;
      if (wrStatusNv && !protectVol)
        volProtect <= data0[BIT_PROTECT_HI:BIT_PROTECT_LO];
      else if (wrStatusVol && protectVol)
        volProtect <= data0[BIT_PROTECT_HI:BIT_PROTECT_LO];
    end
  end

  // Failure flags: a new failure wins over a clear-status in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst || doSoftReset)
    begin
      progErr <= PROG_ERR_DEFAULT;
      eraseErr <= ERASE_ERR_DEFAULT;
    end
    else
    begin
      if (setProgErr)
        progErr <= 1'b1;
      else if (doClear)
        progErr <= 1'b0;
      if (setEraseErr)
        eraseErr <= 1'b1;
      else if (doClear)
        eraseErr <= 1'b0;
    end
  end

  // Write-enable latch; failed operations leave it set for the host
  always_ff @(posedge clk)
  begin
    if (rst || doSoftReset)
      writeLatch <= WRITE_LATCH_DEFAULT;
    else if (doEnable)
      writeLatch <= 1'b1;
    else if (doDisable)
      writeLatch <= 1'b0;
    else if (doWrr || doWrar || engineOk)
      writeLatch <= 1'b0;
  end

  // Busy flag and engine tracking; an error holds busy until cleared
  always_ff @(posedge clk)
  begin
    if (rst || doSoftReset)
    begin
      busy <= BUSY_FLAG_DEFAULT;
      running <= 1'b0;
      suspended <= 1'b0;
      runKind <= KIND_PROGRAM;
    end
    else
    begin
      if (startOp || setProgErr || setEraseErr || doResume)
        busy <= 1'b1;
      else if (engineEnd || doSuspend)
        busy <= 1'b0;
      else if (doClear && !running)
        busy <= 1'b0;
      if (startOp)
      begin
        running <= 1'b1;
        runKind <= doProgram ? KIND_PROGRAM : (doSector ? KIND_SECTOR_ERASE : KIND_WHOLE_ERASE);
      end
      else if (engineEnd)
        running <= 1'b0;
      if (doSuspend)
        suspended <= 1'b1;
      else if (doResume)
        suspended <= 1'b0;
    end
  end

  // Requests to the array engine, one-cycle pulses
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      opStart <= 1'b0;
      opKind <= KIND_PROGRAM;
      opAddr <= 24'h00_0000;
      suspendReq <= 1'b0;
      resumeReq <= 1'b0;
      opAbort <= 1'b0;
    end
    else
    begin
      opStart <= startOp;
      suspendReq <= doSuspend;
      resumeReq <= doResume;
      opAbort <= doSoftReset && running;
      if (startOp)
      begin
        opKind <= doProgram ? KIND_PROGRAM : (doSector ? KIND_SECTOR_ERASE : KIND_WHOLE_ERASE);
        opAddr <= addr;
      end
    end
  end

  // ==========================================================
  // Read data path; output changes on the falling link clock
  logic readActive;
  logic [23:0] readAddr;
  logic [7:0] shiftOut;

  function automatic logic [7:0] regValue(input logic [23:0] a);
    if (a == ADDR_STATUS_ONE_VOL)
      return statusOneVolatile;
    else if (a == ADDR_STATUS_ONE_NV)
      return statusOneNonvolatile;
    else if (a == ADDR_CONFIG_ONE_NV)
      return configOneNonvolatile;
    else
      return 8'h00;
  endfunction : regValue

  // Repeats the selected register so software can poll in one frame
  always_ff @(posedge clk)
  begin
    if (rst || csNQ)
    begin
      readActive <= 1'b0;
      readAddr <= ADDR_STATUS_ONE_VOL;
      shiftOut <= 8'h00;
      so <= 1'b0;
      soOe <= 1'b0;
    end
    else
    begin
      soOe <= readActive;
      if (byteDone && phase == PH_CMD && cmdAccept && byteIn == OPC_READ_STATUS_ONE)
      begin
        readActive <= 1'b1;
        readAddr <= ADDR_STATUS_ONE_VOL;
        shiftOut <= statusOneVolatile;
      end
      else if (byteDone && phase == PH_ADDR && addrCnt == 2'(ADDR_BYTES - 1)
               && opcode == OPC_READ_ANY)
      begin
        readActive <= 1'b1;
        readAddr <= {addr[15:0], byteIn};
        shiftOut <= regValue({addr[15:0], byteIn});
      end
      else if (byteDone && readActive)
        shiftOut <= regValue(readAddr);
      else if (sckFall && readActive)
      begin
        so <= shiftOut[7];
        shiftOut <= {shiftOut[6:0], 1'b0};
      end
    end
  end

endmodule : fsr_status_one

//--- verilog/fsr_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the clock domain
module fsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule : fsr_sync
